// ===== inc/giq_pkg.sv
// Constants, tables and types shared by the inventory round controller
package giq_pkg;

    localparam int          PROFILE_COUNT   = 6;
    localparam logic [2:0]  PROFILE_LAST    = 3'h5;
    localparam logic [2:0]  PROFILE_DEFAULT = 3'h2;
    // Bit n set means profile n is allowed in the restricted regions
    localparam logic [5:0]  REGION_ALLOWED  = 6'h2d;

    localparam int          CNT_W           = 16;
    localparam int          RETRY_W         = 8;
    localparam logic [3:0]  Q_TOP           = 4'hf;
    localparam logic [3:0]  Q_ZERO          = 4'h0;

    localparam logic        ALGO_FIXED      = 1'b0;
    localparam logic        ALGO_DYN1       = 1'b1;

    // Profile fields: modulation 1 = PR-ASK, 0 = DSB-ASK
    localparam logic [5:0]  TBL_MOD_PR      = 6'h2c;
    // PIE code 1 = 1.5:1, 0 = 2:1
    localparam logic [5:0]  TBL_PIE_15      = 6'h3c;
    // Divide ratio code 1 = 64/3, 0 = 8
    localparam logic [5:0]  TBL_DR_643      = 6'h2c;
    localparam logic [15:0] TBL_TARI_NS [PROFILE_COUNT] =
        '{16'h61a8, 16'h30d4, 16'h61a8, 16'h61a8, 16'h186a, 16'h61a8};
    localparam logic [9:0]  TBL_BLF_KHZ [PROFILE_COUNT] =
        '{10'h028, 10'h0a0, 10'h0fa, 10'h12c, 10'h190, 10'h0fa};
    // Miller subcarrier count, 1 = FM0
    localparam logic [2:0]  TBL_MILLER  [PROFILE_COUNT] =
        '{3'h1, 3'h2, 3'h4, 3'h4, 3'h1, 3'h2};

    typedef enum logic [2:0] {
        GIQ_IDLE,
        GIQ_ROUND,
        GIQ_WAIT,
        GIQ_REP,
        GIQ_EVAL,
        GIQ_DONE
    } giq_state_t;

endpackage : giq_pkg

// ===== rtl/giq_inventory_ctrl.sv
// Inventory round controller: profile select, fixed-Q and dynamic-Q sequencing
module giq_inventory_ctrl (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        region_restricted,
    input  wire logic        profile_load,
    input  wire logic [2:0]  profile_sel,
    input  wire logic        algo_sel,
    input  wire logic        start_cycle,
    input  wire logic [3:0]  fixed_q,
    input  wire logic [7:0]  retry_count,
    input  wire logic        opt_until_empty,
    input  wire logic        opt_toggle_target,
    input  wire logic [3:0]  q_start,
    input  wire logic [3:0]  lower_adjust_limit,
    input  wire logic [3:0]  upper_adjust_limit,
    input  wire logic [15:0] max_repeat_count,
    input  wire logic [3:0]  high_threshold_factor,
    input  wire logic [3:0]  low_threshold_factor,
    input  wire logic        slot_done,
    input  wire logic        rn16_timeout,
    input  wire logic        epc_timeout,
    input  wire logic        tag_read,
    input  wire logic        round_cut_off,
    output logic [2:0]       active_profile,
    output logic             profile_reject,
    output logic             prof_mod_pr,
    output logic [15:0]      prof_tari_ns,
    output logic             prof_pie_15,
    output logic [9:0]       prof_blf_khz,
    output logic [2:0]       prof_miller,
    output logic             prof_dr_643,
    output logic             send_query,
    output logic             send_query_rep,
    output logic [3:0]       query_q,
    output logic             target_flag,
    output logic             cycle_busy,
    output logic             cycle_done,
    output logic [15:0]      round_rn16,
    output logic [15:0]      round_epc,
    output logic [15:0]      round_tags
);

    // Legal profile number for the current regional variant
    function automatic logic profile_ok(input logic [2:0] p, input logic restricted);
        logic ok;
        ok = (p <= giq_pkg::PROFILE_LAST);
        if (ok && restricted) begin
            ok = giq_pkg::REGION_ALLOWED[p];
        end
        return ok;
    endfunction : profile_ok

    // Clamp a Q value into the configured window, upper bound winning on a bad window
    function automatic logic [3:0] q_clamp(input logic [3:0] q, input logic [3:0] lo,
                                           input logic [3:0] hi);
        logic [3:0] r;
        r = q;
        if (r < lo) begin
            r = lo;
        end
        if (r > hi) begin
            r = hi;
        end
        return r;
    endfunction : q_clamp

    // ---------------- Profile selection ----------------
    logic [2:0] profile_r;
    logic [2:0] profile_nxt;
    logic       reject_r;
    logic       reject_nxt;

    // illegal numbers leave the selection untouched
    always_comb begin
        profile_nxt = profile_r;
        reject_nxt  = 1'b0;
        if (profile_load) begin
            if (profile_ok(profile_sel, region_restricted)) begin
                profile_nxt = profile_sel;
            end else begin
                reject_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            profile_r <= giq_pkg::PROFILE_DEFAULT;
            reject_r  <= 1'b0;
        end else begin
            profile_r <= profile_nxt;
            reject_r  <= reject_nxt;
        end
    end

    assign active_profile = profile_r;
    assign profile_reject = reject_r;

    giq_profile_rom u_rom (
        .ref_clk      (ref_clk),
        .rstn         (rstn),
        .prof_idx     (profile_r),
        .prof_mod_pr  (prof_mod_pr),
        .prof_tari_ns (prof_tari_ns),
        .prof_pie_15  (prof_pie_15),
        .prof_blf_khz (prof_blf_khz),
        .prof_miller  (prof_miller),
        .prof_dr_643  (prof_dr_643)
    );

    // ---------------- Round sequencer ----------------
    giq_pkg::giq_state_t state_r;
    giq_pkg::giq_state_t state_nxt;
    logic [3:0]  q_r;
    logic [3:0]  q_nxt;
    logic        algo_r;
    logic        algo_nxt;
    logic [15:0] slot_r;
    logic [15:0] slot_nxt;
    logic [7:0]  retry_r;
    logic [7:0]  retry_nxt;
    logic        target_r;
    logic        target_nxt;
    logic        counting;
    logic        round_clear;
    logic [15:0] last_slot;
    logic        round_end;
    logic [19:0] hi_prod;
    logic [19:0] lo_prod;
    logic [19:0] rn16_w;
    logic        q_down;
    logic        q_up;
    logic        dyn_stop;

    assign counting    = (state_r == giq_pkg::GIQ_WAIT) || (state_r == giq_pkg::GIQ_REP);
    assign round_clear = (state_r == giq_pkg::GIQ_ROUND);
    assign last_slot   = 16'((17'h00001 << q_r) - 17'h00001);
    // dynamic rounds stop at the repeat limit as well as after all slots
    assign round_end   = (slot_r == last_slot) ||
                         ((algo_r == giq_pkg::ALGO_DYN1) && (slot_r == max_repeat_count));

    // Round event counters: tags read, EPC timeouts, RN16 timeouts
    logic [2:0] ev_in;
    assign ev_in = {tag_read, epc_timeout, rn16_timeout};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : gen_cnt
            logic [15:0] c_r;
            logic [15:0] c_nxt;
            // counters restart with each Query; saturate instead of wrapping
            always_comb begin
                c_nxt = c_r;
                if (round_clear) begin
                    c_nxt = 16'h0000;
                end else if (counting && ev_in[gi] && (c_r != 16'hffff)) begin
                    c_nxt = c_r + 16'h0001;
                end
            end
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    c_r <= 16'h0000;
                end else begin
                    c_r <= c_nxt;
                end
            end
        end
    endgenerate

    assign round_rn16 = gen_cnt[0].c_r;
    assign round_epc  = gen_cnt[1].c_r;
    assign round_tags = gen_cnt[2].c_r;

    // Threshold products sized so a 16-bit count times a 4-bit factor never overflows
    assign hi_prod = gen_cnt[1].c_r * high_threshold_factor;
    assign lo_prod = gen_cnt[1].c_r * low_threshold_factor;
    assign rn16_w  = {4'h0, gen_cnt[0].c_r};
    assign q_down  = (rn16_w > hi_prod);
    assign q_up    = (rn16_w < lo_prod);
    // empty round at Q zero, or at the lower limit when that is above zero
    assign dyn_stop = (round_tags == 16'h0000) &&
                      ((q_r == giq_pkg::Q_ZERO) || (q_r == lower_adjust_limit));

    // Cycle state machine
    always_comb begin
        state_nxt  = state_r;
        q_nxt      = q_r;
        algo_nxt   = algo_r;
        slot_nxt   = slot_r;
        retry_nxt  = retry_r;
        target_nxt = target_r;
        case (state_r)
            giq_pkg::GIQ_IDLE: begin
                if (start_cycle) begin
                    algo_nxt  = algo_sel;
                    retry_nxt = retry_count;
                    // dynamic cycles open at the initial Q inside the limits
                    if (algo_sel == giq_pkg::ALGO_DYN1) begin
                        q_nxt = q_clamp(q_start, lower_adjust_limit, upper_adjust_limit);
                    end else begin
                        q_nxt = fixed_q;
                    end
                    state_nxt = giq_pkg::GIQ_ROUND;
                end
            end
            giq_pkg::GIQ_ROUND: begin
                slot_nxt  = 16'h0000;
                state_nxt = giq_pkg::GIQ_WAIT;
            end
            giq_pkg::GIQ_WAIT: begin
                // hop or dwell boundary ends the round early
                if (round_cut_off) begin
                    state_nxt = giq_pkg::GIQ_EVAL;
                end else if (slot_done) begin
                    if (round_end) begin
                        state_nxt = giq_pkg::GIQ_EVAL;
                    end else begin
                        slot_nxt  = slot_r + 16'h0001;
                        state_nxt = giq_pkg::GIQ_REP;
                    end
                end
            end
            giq_pkg::GIQ_REP: begin
                if (round_cut_off) begin
                    state_nxt = giq_pkg::GIQ_EVAL;
                end else begin
                    state_nxt = giq_pkg::GIQ_WAIT;
                end
            end
            giq_pkg::GIQ_EVAL: begin
                // optional A/B flip at the end of every round
                if (opt_toggle_target) begin
                    target_nxt = ~target_r;
                end
                if (algo_r == giq_pkg::ALGO_FIXED) begin
                    // repeat until empty, or run the configured retries
                    if (opt_until_empty) begin
                        state_nxt = (round_tags == 16'h0000) ? giq_pkg::GIQ_DONE
                                                             : giq_pkg::GIQ_ROUND;
                    end else if (retry_r == 8'h00) begin
                        state_nxt = giq_pkg::GIQ_DONE;
                    end else begin
                        retry_nxt = retry_r - 8'h01;
                        state_nxt = giq_pkg::GIQ_ROUND;
                    end
                end else if (dyn_stop) begin
                    state_nxt = giq_pkg::GIQ_DONE;
                end else begin
                    // within a cycle Q moves here only, between rounds
                    if (q_down && (q_r > lower_adjust_limit)) begin
                        q_nxt = q_r - 4'h1;
                    end else if (q_up && (q_r < upper_adjust_limit) && (q_r != giq_pkg::Q_TOP)) begin
                        q_nxt = q_r + 4'h1;
                    end
                    // in-band ratio leaves Q as it was
                    state_nxt = giq_pkg::GIQ_ROUND;
                end
            end
            giq_pkg::GIQ_DONE: begin
                state_nxt = giq_pkg::GIQ_IDLE;
            end
            default: begin
                state_nxt = giq_pkg::GIQ_IDLE;
            end
        endcase
    end

    // Q register is four bits wide, 0 to 15
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r  <= giq_pkg::GIQ_IDLE;
            q_r      <= giq_pkg::Q_ZERO;
            algo_r   <= giq_pkg::ALGO_FIXED;
            slot_r   <= 16'h0000;
            retry_r  <= 8'h00;
            target_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            q_r      <= q_nxt;
            algo_r   <= algo_nxt;
            slot_r   <= slot_nxt;
            retry_r  <= retry_nxt;
            target_r <= target_nxt;
        end
    end

    // Command strobes decoded from state, one cycle each
    assign send_query     = (state_r == giq_pkg::GIQ_ROUND);
    assign send_query_rep = (state_r == giq_pkg::GIQ_REP);
    assign cycle_done     = (state_r == giq_pkg::GIQ_DONE);
    assign cycle_busy     = (state_r != giq_pkg::GIQ_IDLE);
    assign query_q        = q_r;
    assign target_flag    = target_r;

    // ---------------- Assertions ----------------
    sequence seq_round_open;
        (state_r == giq_pkg::GIQ_ROUND) ##1 (state_r == giq_pkg::GIQ_WAIT);
    endsequence

    sequence seq_dyn_eval;
        (state_r == giq_pkg::GIQ_EVAL) && (algo_r == giq_pkg::ALGO_DYN1) && !dyn_stop;
    endsequence

    AST_PROFILE_REJECT: assert property (@(posedge ref_clk) disable iff (!rstn)
        profile_load && !profile_ok(profile_sel, region_restricted)
        |=> profile_reject && (active_profile == $past(active_profile)))
        else $error("illegal profile was accepted");

    AST_PROFILE_RANGE: assert property (@(posedge ref_clk) disable iff (!rstn)
        profile_load && profile_ok(profile_sel, region_restricted)
        |=> (active_profile == $past(profile_sel)) ##1 (prof_miller != 3'h0))
        else $error("legal profile not applied");

    // counters zero at the start of the round
    AST_COUNTERS_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
        seq_round_open |-> (round_rn16 == 16'h0000) && (round_epc == 16'h0000)
                           && (round_tags == 16'h0000))
        else $error("round counters not cleared");

    // fixed mode issues the first Query of a cycle with the fixed Q
    AST_FIXED_Q: assert property (@(posedge ref_clk) disable iff (!rstn)
        send_query && (algo_r == giq_pkg::ALGO_FIXED) && !$past(cycle_busy, 1)
        |-> query_q == $past(fixed_q))
        else $error("fixed Q not used");

    AST_CUT_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
        round_cut_off && counting |=> state_r == giq_pkg::GIQ_EVAL)
        else $error("round not cut off");

    // QueryRep count bounded by the repeat limit
    AST_REP_LIMIT: assert property (@(posedge ref_clk) disable iff (!rstn)
        send_query_rep && (algo_r == giq_pkg::ALGO_DYN1) |-> slot_r <= max_repeat_count)
        else $error("too many QueryReps");

    AST_Q_DOWN: assert property (@(posedge ref_clk) disable iff (!rstn)
        seq_dyn_eval and (q_down && (q_r > lower_adjust_limit))
        |=> query_q == $past(q_r) - 4'h1)
        else $error("Q not decremented");

    AST_Q_UP: assert property (@(posedge ref_clk) disable iff (!rstn)
        seq_dyn_eval and (!q_down && q_up && (q_r < upper_adjust_limit))
        |=> query_q == $past(q_r) + 4'h1)
        else $error("Q not incremented");

    AST_Q_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
        seq_dyn_eval and (!q_down && !q_up) |=> $stable(query_q))
        else $error("Q changed inside band");

    AST_Q_START: assert property (@(posedge ref_clk) disable iff (!rstn)
        !cycle_busy && start_cycle && (algo_sel == giq_pkg::ALGO_DYN1)
        |=> query_q == q_clamp($past(q_start), $past(lower_adjust_limit),
                               $past(upper_adjust_limit)))
        else $error("dynamic cycle started at wrong Q");

    AST_Q_FROZEN: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_r != giq_pkg::GIQ_EVAL) && (state_r != giq_pkg::GIQ_IDLE) |=> $stable(query_q))
        else $error("Q changed mid round");

    // empty round at Q zero closes the cycle
    AST_DYN_END: assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_r == giq_pkg::GIQ_EVAL) && (algo_r == giq_pkg::ALGO_DYN1)
        && (q_r == giq_pkg::Q_ZERO) && (round_tags == 16'h0000)
        |=> cycle_done ##1 !cycle_busy)
        else $error("dynamic cycle did not end");

endmodule : giq_inventory_ctrl

// ===== rtl/giq_profile_rom.sv
// Air-link profile table with registered read data
module giq_profile_rom (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [2:0]  prof_idx,
    output logic             prof_mod_pr,
    output logic [15:0]      prof_tari_ns,
    output logic             prof_pie_15,
    output logic [9:0]       prof_blf_khz,
    output logic [2:0]       prof_miller,
    output logic             prof_dr_643
);

    logic        mod_nxt;
    logic [15:0] tari_nxt;
    logic        pie_nxt;
    logic [9:0]  blf_nxt;
    logic [2:0]  miller_nxt;
    logic        dr_nxt;

    // table lookup; index above the last profile never reaches here
    always_comb begin
        mod_nxt    = giq_pkg::TBL_MOD_PR[prof_idx];
        tari_nxt   = giq_pkg::TBL_TARI_NS[prof_idx];
        pie_nxt    = giq_pkg::TBL_PIE_15[prof_idx];
        blf_nxt    = giq_pkg::TBL_BLF_KHZ[prof_idx];
        miller_nxt = giq_pkg::TBL_MILLER[prof_idx];
        dr_nxt     = giq_pkg::TBL_DR_643[prof_idx];
    end

    // Registered outputs, one cycle behind the index
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prof_mod_pr  <= 1'b0;
            prof_tari_ns <= 16'h0000;
            prof_pie_15  <= 1'b0;
            prof_blf_khz <= 10'h000;
            prof_miller  <= 3'h0;
            prof_dr_643  <= 1'b0;
        end else begin
            prof_mod_pr  <= mod_nxt;
            prof_tari_ns <= tari_nxt;
            prof_pie_15  <= pie_nxt;
            prof_blf_khz <= blf_nxt;
            prof_miller  <= miller_nxt;
            prof_dr_643  <= dr_nxt;
        end
    end

endmodule : giq_profile_rom

// ===== tb/gen2_inventory_q_controller_bench.sv
// Self-checking bench for the inventory round controller
module gen2_inventory_q_controller_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'b0, rstn = 1'b0, region_restricted = 1'b0, profile_load = 1'b0;
    logic        algo_sel = 1'b0, start_cycle = 1'b0, opt_until_empty = 1'b0, refill = 1'b0;
    logic        opt_toggle_target = 1'b1, round_cut_off = 1'b0;
    logic [1:0]  stall = 2'h2;
    logic [2:0]  profile_sel = 3'h0;
    logic [3:0]  fixed_q = 4'h0, q_start = 4'h0, lower_adjust_limit = 4'h0, tag_total = 4'h0;
    logic [3:0]  upper_adjust_limit = 4'hf, high_threshold_factor = 4'h1;
    logic [3:0]  low_threshold_factor = 4'h1;
    logic [7:0]  retry_count = 8'h0;
    logic [15:0] max_repeat_count = 16'h0;
    logic        slot_done, rn16_timeout, epc_timeout, tag_read, profile_reject, prof_mod_pr;
    logic        prof_pie_15, prof_dr_643, send_query, send_query_rep, target_flag;
    logic        cycle_busy, cycle_done;
    logic [2:0]  active_profile, prof_miller;
    logic [3:0]  query_q;
    logic [3:0]  q_hist [16];
    logic [9:0]  prof_blf_khz;
    logic [15:0] prof_tari_ns, round_rn16, round_epc, round_tags;
    int          failures = 0, total_checks = 0, n_q = 0, n_rep = 0;

    // 40 MHz reference clock
    always #12.5 ref_clk = ~ref_clk;

    giq_inventory_ctrl uut (
        .ref_clk, .rstn, .region_restricted, .profile_load, .profile_sel, .algo_sel,
        .start_cycle, .fixed_q, .retry_count, .opt_until_empty, .opt_toggle_target, .q_start,
        .lower_adjust_limit, .upper_adjust_limit, .max_repeat_count, .high_threshold_factor,
        .low_threshold_factor, .slot_done, .rn16_timeout, .epc_timeout, .tag_read,
        .round_cut_off, .active_profile, .profile_reject, .prof_mod_pr, .prof_tari_ns,
        .prof_pie_15, .prof_blf_khz, .prof_miller, .prof_dr_643, .send_query, .send_query_rep,
        .query_q, .target_flag, .cycle_busy, .cycle_done, .round_rn16, .round_epc, .round_tags
    );
    giq_tag_pop pop (
        .ref_clk, .refill, .tag_total, .stall, .send_query, .send_query_rep, .query_q,
        .slot_done, .rn16_timeout, .epc_timeout, .tag_read
    );

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // Strobe log; Q of every Query kept for later comparison
    always @(negedge ref_clk) begin
        if (send_query === 1'b1) begin
            q_hist[n_q[3:0]] = query_q;
            n_q++;
        end
        if (send_query_rep === 1'b1) begin
            n_rep++;
            check(query_q, q_hist[n_q[3:0] - 4'h1], "q moved mid round");
        end
    end

    // Refill tags, start a cycle, wait for its end under a bound
    task automatic run_cycle(input logic algo, input int cut);
        tick;
        refill = 1'b1;
        tick;
        refill = 1'b0;
        n_q = 0;
        n_rep = 0;
        algo_sel = algo;
        start_cycle = 1'b1;
        tick;
        start_cycle = 1'b0;
        repeat (cut) tick;
        // Second start must be ignored while busy, then the cut ends the round
        start_cycle = (cut > 0);
        round_cut_off = (cut > 0);
        tick;
        start_cycle = 1'b0;
        round_cut_off = 1'b0;
        for (int i = 0; i < 600; i++) begin
            @(negedge ref_clk);
            if (cycle_done === 1'b1) begin
                check(cycle_busy, 1'b1, "busy at done");
                @(negedge ref_clk);
                check(cycle_busy, 1'b0, "idle after done");
                return;
            end
        end
        failures++;
        $display("wrong value at %0t: cycle never ended", $time);
        finish_test;
    endtask : run_cycle

    task automatic profile_test;
        logic [15:0] tari [6] = '{16'h61a8, 16'h30d4, 16'h61a8, 16'h61a8, 16'h186a, 16'h61a8};
        logic [9:0]  blf [6] = '{10'h028, 10'h0a0, 10'h0fa, 10'h12c, 10'h190, 10'h0fa};
        logic [2:0]  mil [6] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h1, 3'h2};
        logic [5:0]  pr = 6'h2c;
        logic [5:0]  pie = 6'h3c;
        logic [2:0]  ep = 3'h2;
        logic        ok;
        tick;
        check(active_profile, 3'h2, "default profile");
        check(prof_tari_ns, 16'h61a8, "default tari");
        check(query_q, 4'h0, "q after reset");
        for (int r = 0; r < 2; r++) begin
            for (int p = 0; p < 8; p++) begin
                ok = (p < 6) && !(r == 1 && (p == 1 || p == 4));
                if (ok) ep = p[2:0];
                region_restricted = r[0];
                profile_sel = p[2:0];
                profile_load = 1'b1;
                tick;
                profile_load = 1'b0;
                @(negedge ref_clk);
                check(active_profile, ep, "profile");
                check(profile_reject, !ok, "reject");
                tick;
                check(prof_tari_ns, tari[ep], "tari");
                check(prof_blf_khz, blf[ep], "link rate");
                check(prof_miller, mil[ep], "encoding");
                check({prof_mod_pr, prof_pie_15, prof_dr_643}, {pr[ep], pie[ep], pr[ep]}, "mod");
            end
        end
        region_restricted = 1'b0;
        $display("test profiles done");
    endtask : profile_test

    // Fixed Q: every slot tried unless the round is cut off, retries or until empty, flag flips per round
    task automatic fixed_test(input logic [7:0] rc, input logic ue, input logic [3:0] tg,
                              input int nq, input int cut);
        logic t0;
        t0 = target_flag;
        fixed_q = cut > 0 ? 4'hf : 4'h2;
        retry_count = rc;
        opt_until_empty = ue;
        tag_total = tg;
        run_cycle(1'b0, cut);
        check(n_q[15:0], nq[15:0], "rounds");
        check(q_hist[0], fixed_q, "fixed q");
        check(target_flag, t0 ^ nq[0], "target flag");
        if (cut == 0) check(n_rep[15:0], 16'h3 * nq[15:0], "reps");
        if (ue) check(round_tags, 16'h0, "last round empty");
        opt_until_empty = 1'b0;
        repeat (4) tick;
        $display("test fixed done");
    endtask : fixed_test

    // Dynamic Q: expected Q of each round packed one nibble per round
    task automatic dyn_test(input logic [3:0] qs, lo, hi, input logic [15:0] mr,
                            input logic [3:0] tg, input logic [31:0] seq, input int nq, nr);
        logic t0;
        t0 = target_flag;
        q_start = qs;
        lower_adjust_limit = lo;
        upper_adjust_limit = hi;
        max_repeat_count = mr;
        tag_total = tg;
        run_cycle(1'b1, 0);
        check(n_q[15:0], nq[15:0], "rounds");
        check(n_rep[15:0], nr[15:0], "reps");
        for (int i = 0; i < nq; i++) check(q_hist[i], seq[4 * i +: 4], "q seq");
        // Final round is empty, so every one of its slots timed out
        check(round_rn16, 16'h1 << seq[4 * (nq - 1) +: 4], "last round rn16");
        check(round_epc, 16'h0, "last round epc");
        check(target_flag, t0 ^ (opt_toggle_target & nq[0]), "target flag");
        $display("test dynamic done");
    endtask : dyn_test

    // Reset for ten cycles, then every scenario
    initial begin
        repeat (10) tick;
        rstn = 1'b1;
        tick;
        profile_test;
        fixed_test(8'h2, 1'b0, 4'h0, 3, 0);
        fixed_test(8'h0, 1'b1, 4'h3, 2, 0);
        fixed_test(8'h0, 1'b0, 4'h0, 1, 20);
        dyn_test(4'h4, 4'h0, 4'hf, 16'h3, 4'h0, 32'h01234, 5, 10);
        dyn_test(4'h9, 4'h3, 4'h5, 16'hffff, 4'h0, 32'h345, 3, 53);
        // Collisions raise Q, a clean round holds it, empty rounds lower it
        opt_toggle_target = 1'b0;
        dyn_test(4'h1, 4'h0, 4'h4, 16'hffff, 4'h4, 32'h01221, 5, 8);
        finish_test;
    end
endmodule : gen2_inventory_q_controller_bench

// ===== tb/giq_tag_pop.sv
// Behavioural population of up to eight passive tags on the air link
module giq_tag_pop (
    input  wire logic       ref_clk,
    input  wire logic       refill,
    input  wire logic [3:0] tag_total,
    input  wire logic [1:0] stall,
    input  wire logic       send_query,
    input  wire logic       send_query_rep,
    input  wire logic [3:0] query_q,
    output logic            slot_done,
    output logic            rn16_timeout,
    output logic            epc_timeout,
    output logic            tag_read
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt [8];
    bit live [8];
    int seed = 0;
    int hits;
    int who;
    initial begin
        {slot_done, rn16_timeout, epc_timeout, tag_read} = 4'h0;
    end
    // One slot per strobe; seen mid-cycle to stay clear of the edge race
    always @(negedge ref_clk) begin
        if (refill) begin
            for (int i = 0; i < 8; i++) live[i] = (i < tag_total);
        end else if (send_query || send_query_rep) begin
            for (int i = 0; i < 8; i++) begin
                if (send_query) cnt[i] = (i * 5 + seed) & ((1 << query_q) - 1);
                else cnt[i] = cnt[i] - 1;
            end
            if (send_query) seed = seed + 3;
            hits = 0;
            for (int i = 0; i < 8; i++) begin
                if (live[i] && cnt[i] == 0) begin
                    hits++;
                    who = i;
                end
            end
            // Slow answer when asked, outcome then slot end
            @(posedge ref_clk);
            repeat (stall) @(posedge ref_clk);
            #1;
            rn16_timeout = (hits == 0);
            epc_timeout = (hits > 1);
            tag_read = (hits == 1);
            if (hits == 1) live[who] = 0;
            @(posedge ref_clk);
            #1;
            {rn16_timeout, epc_timeout, tag_read, slot_done} = 4'h1;
            @(posedge ref_clk);
            #1;
            slot_done = 1'b0;
        end
    end
endmodule : giq_tag_pop
